// ### hw/gmf_defs.svh
// Constants for the line controller: register byte addresses, field
// positions, reset values and widths. Assumes APB with 32-bit data.
`ifndef GMF_DEFS_SVH
`define GMF_DEFS_SVH

`define GMF_LINES 32
`define GMF_DIV_W 14
`define GMF_DIV_MSB 13
`define GMF_DIV_LSB 0
`define GMF_PROTECT_BIT 0

`define GMF_ADDR_OUT_DATA 32'h400e0e38
`define GMF_ADDR_SEL_HIGH 32'h400e0e70
`define GMF_ADDR_SEL_LOW 32'h400e0e74
`define GMF_ADDR_FLT_GLITCH 32'h400e0e80
`define GMF_ADDR_FLT_DEBOUNCE 32'h400e0e84
`define GMF_ADDR_FLT_STATE 32'h400e0e88
`define GMF_ADDR_DIVIDER 32'h400e0e8c
`define GMF_ADDR_PD_OFF 32'h400e0e90
`define GMF_ADDR_PD_ON 32'h400e0e94
`define GMF_ADDR_PD_STATE 32'h400e0e98
`define GMF_ADDR_DW_ON 32'h400e0ea0
`define GMF_ADDR_DW_OFF 32'h400e0ea4
`define GMF_ADDR_DW_STATE 32'h400e0ea8
`define GMF_ADDR_WP_MODE 32'h400e0ee4

`define GMF_RST_VEC 32'h00000000
`define GMF_RST_DIV 14'h0000

`endif

// ### hw/gmf_line_filter.sv
// Input filter for one line: glitch filter or slow debounce filter.
// Assumes pin is synchronous to pclk and sample_tick is a pulse.
`timescale 1ns/10ps
`default_nettype none

module gmf_line_filter
(
    input wire logic pclk, // Peripheral clock
    input wire logic presetn, // Async reset, active low
    input wire logic pin, // Raw line level
    input wire logic use_debounce, // 1 selects the debounce filter
    input wire logic sample_tick, // Debounce sampling pulse
    output logic filt // Filtered level
);

    logic pin_q;
    logic glitch_val;
    logic deb_prev;
    logic deb_val;

    // A level must hold across two edges to pass
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_q <= 1'b0;
            glitch_val <= 1'b0;
        end
        else
        begin
            pin_q <= pin;
            if (pin == pin_q)
            begin
                glitch_val <= pin;
            end
        end
    end

    // Two equal samples half a period apart are needed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            deb_prev <= 1'b0;
            deb_val <= 1'b0;
        end
        else if (sample_tick)
        begin
            deb_prev <= pin;
            if (pin == deb_prev)
            begin
                deb_val <= pin;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            filt <= 1'b0;
        end
        else
        begin
            filt <= use_debounce ? deb_val : glitch_val;
        end
    end

endmodule

`default_nettype wire

// ### hw/gmf_pkg.sv
// Types shared by the line controller files.
// Assumes the constants header is compiled alongside.
package gmf_pkg;

    // Encoding is {select high bit, select low bit}
    typedef enum logic [1:0] {
        GMF_FUNC_A = 2'b00,
        GMF_FUNC_B = 2'b01,
        GMF_FUNC_C = 2'b10,
        GMF_FUNC_D = 2'b11
    } gmf_func_type;

    typedef logic [31:0] gmf_word_type;

endpackage

// ### hw/gmf_slow_div.sv
// Debounce sampling divider: one pclk pulse every (div + 1) slow ticks.
// Assumes slck_tick is a one-cycle pulse, synchronous to pclk.
`timescale 1ns/10ps
`default_nettype none

module gmf_slow_div
(
    input wire logic pclk, // Peripheral clock
    input wire logic presetn, // Async reset, active low
    input wire logic slck_tick, // One pulse per slow clock period
    input wire logic [13:0] div, // Divider field
    output logic sample_tick // Pulse each half debounce period
);

    logic [13:0] count;

    // Half of ((div + 1) * 2) slow periods per pulse
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count <= 14'h0000;
            sample_tick <= 1'b0;
        end
        else
        begin
            sample_tick <= 1'b0;
            if (slck_tick)
            begin
                if (count >= div)
                begin
                    count <= 14'h0000;
                    sample_tick <= 1'b1;
                end
                else
                begin
                    count <= count + 14'h0001;
                end
            end
        end
    end

endmodule

`default_nettype wire

// ### hw/gmf_top.sv
// Line controller top: function select, input filters, pull-downs and
// gated direct writes of the output data, behind an APB slave.
// Assumes pins and slck_tick are synchronous to pclk.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/10ps
`default_nettype none
`include "gmf_defs.svh"

module gmf_top
(
    input wire logic pclk, // Peripheral clock, 125 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic [31:0] paddr, // APB byte address
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction, 1 = write
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic slck_tick, // Slow clock enable pulse
    input wire logic [31:0] pin_in, // Line levels from the pads
    output logic [31:0] periph_a_in, // Filtered lines to function A
    output logic [31:0] periph_b_in, // Filtered lines to function B
    output logic [31:0] periph_c_in, // Filtered lines to function C
    output logic [31:0] periph_d_in, // Filtered lines to function D
    output logic [31:0] pad_pulldown, // Pull-down enable per pad
    output logic [31:0] out_data // Output data value per line
);
    import gmf_pkg::*;

    gmf_word_type sel_low;
    gmf_word_type sel_high;
    gmf_word_type filter_debounce;
    gmf_word_type pulldown_en;
    gmf_word_type direct_write;
    logic [13:0] divider;
    logic write_protect_enable;
    logic [31:0] filtered;
    logic sample_tick;
    logic access;
    logic wr_strobe;
    logic setup;
    logic mapped;
    logic [31:0] next_rdata;

    // APB handshake

    assign setup = psel && !penable;
    assign access = psel && penable && pready;
    assign wr_strobe = access && pwrite;

    // One wait-free answer: pready rises the cycle after setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
        end
        else
        begin
            pready <= setup;
        end
    end

    always_comb
    begin
        mapped = 1'b1;
        case (paddr)
            `GMF_ADDR_OUT_DATA: mapped = 1'b1;
            `GMF_ADDR_SEL_HIGH: mapped = 1'b1;
            `GMF_ADDR_SEL_LOW: mapped = 1'b1;
            `GMF_ADDR_FLT_GLITCH: mapped = 1'b1;
            `GMF_ADDR_FLT_DEBOUNCE: mapped = 1'b1;
            `GMF_ADDR_FLT_STATE: mapped = 1'b1;
            `GMF_ADDR_DIVIDER: mapped = 1'b1;
            `GMF_ADDR_PD_OFF: mapped = 1'b1;
            `GMF_ADDR_PD_ON: mapped = 1'b1;
            `GMF_ADDR_PD_STATE: mapped = 1'b1;
            `GMF_ADDR_DW_ON: mapped = 1'b1;
            `GMF_ADDR_DW_OFF: mapped = 1'b1;
            `GMF_ADDR_DW_STATE: mapped = 1'b1;
            `GMF_ADDR_WP_MODE: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Read mux; write-only registers read as zero
    always_comb
    begin
        next_rdata = 32'h00000000;
        case (paddr)
            `GMF_ADDR_OUT_DATA: next_rdata = out_data;
            `GMF_ADDR_SEL_HIGH: next_rdata = sel_high;
            `GMF_ADDR_SEL_LOW: next_rdata = sel_low;
            `GMF_ADDR_FLT_STATE: next_rdata = filter_debounce;
            `GMF_ADDR_DIVIDER: next_rdata = {18'h00000, divider};
            `GMF_ADDR_PD_STATE: next_rdata = ~pulldown_en;
            `GMF_ADDR_DW_STATE: next_rdata = direct_write;
            `GMF_ADDR_WP_MODE: next_rdata = {31'h00000000,
                write_protect_enable};
            default: next_rdata = 32'h00000000;
        endcase
    end

    // Read data and error are captured at setup, stand through access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
        else if (setup)
        begin
            prdata <= pwrite ? 32'h00000000 : next_rdata;
            pslverr <= !mapped;
        end
        else
        begin
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end
    end

    // Write protection

    // enable held in mode bit 0
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            write_protect_enable <= 1'b0;
        end
        else if (wr_strobe && paddr == `GMF_ADDR_WP_MODE)
        begin
            write_protect_enable <= pwdata[`GMF_PROTECT_BIT];
        end
    end

    // Function select registers

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sel_low <= `GMF_RST_VEC;
            sel_high <= `GMF_RST_VEC;
        end
        else if (wr_strobe && !write_protect_enable)
        begin
            if (paddr == `GMF_ADDR_SEL_LOW)
            begin
                sel_low <= pwdata;
            end
            if (paddr == `GMF_ADDR_SEL_HIGH)
            begin
                sel_high <= pwdata;
            end
        end
    end

    // Filter kind, not write protected

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            filter_debounce <= `GMF_RST_VEC;
        end
        else if (wr_strobe)
        begin
            if (paddr == `GMF_ADDR_FLT_GLITCH)
            begin
                filter_debounce <= filter_debounce & ~pwdata;
            end
            if (paddr == `GMF_ADDR_FLT_DEBOUNCE)
            begin
                filter_debounce <= filter_debounce | pwdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            divider <= `GMF_RST_DIV;
        end
        else if (wr_strobe && paddr == `GMF_ADDR_DIVIDER)
        begin
            divider <= pwdata[`GMF_DIV_MSB:`GMF_DIV_LSB];
        end
    end

    // Pull-downs

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pulldown_en <= `GMF_RST_VEC;
        end
        else if (wr_strobe && !write_protect_enable)
        begin
            if (paddr == `GMF_ADDR_PD_OFF)
            begin
                pulldown_en <= pulldown_en & ~pwdata;
            end
            if (paddr == `GMF_ADDR_PD_ON)
            begin
                pulldown_en <= pulldown_en | pwdata;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pad_pulldown <= `GMF_RST_VEC;
        end
        else
        begin
            pad_pulldown <= pulldown_en;
        end
    end

    // Direct output writes

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            direct_write <= `GMF_RST_VEC;
        end
        else if (wr_strobe && !write_protect_enable)
        begin
            if (paddr == `GMF_ADDR_DW_ON)
            begin
                direct_write <= direct_write | pwdata;
            end
            if (paddr == `GMF_ADDR_DW_OFF)
            begin
                direct_write <= direct_write & ~pwdata;
            end
        end
    end

    // Lines not enabled keep their value, so software can touch
    // a subset of lines without a read-modify-write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_data <= `GMF_RST_VEC;
        end
        else if (wr_strobe && paddr == `GMF_ADDR_OUT_DATA)
        begin
            out_data <= (out_data & ~direct_write) |
                (pwdata & direct_write);
        end
    end

    // Input filters

    gmf_slow_div u_div
    (
        .pclk(pclk),
        .presetn(presetn),
        .slck_tick(slck_tick),
        .div(divider),
        .sample_tick(sample_tick)
    );

    genvar i;
    generate
        for (i = 0; i < `GMF_LINES; i = i + 1)
        begin : g_line
            gmf_line_filter u_filt
            (
                .pclk(pclk),
                .presetn(presetn),
                .pin(pin_in[i]),
                .use_debounce(filter_debounce[i]),
                .sample_tick(sample_tick),
                .filt(filtered[i])
            );
        end
    endgenerate

    // Function routing

    // Unselected functions see a quiet low rather than the pin
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            periph_a_in <= `GMF_RST_VEC;
            periph_b_in <= `GMF_RST_VEC;
            periph_c_in <= `GMF_RST_VEC;
            periph_d_in <= `GMF_RST_VEC;
        end
        else
        begin
            for (int n = 0; n < `GMF_LINES; n++)
            begin
                case (gmf_func_type'({sel_high[n], sel_low[n]}))
                    GMF_FUNC_A:
                    begin
                        periph_a_in[n] <= filtered[n];
                        periph_b_in[n] <= 1'b0;
                        periph_c_in[n] <= 1'b0;
                        periph_d_in[n] <= 1'b0;
                    end
                    GMF_FUNC_B:
                    begin
                        periph_a_in[n] <= 1'b0;
                        periph_b_in[n] <= filtered[n];
                        periph_c_in[n] <= 1'b0;
                        periph_d_in[n] <= 1'b0;
                    end
                    GMF_FUNC_C:
                    begin
                        periph_a_in[n] <= 1'b0;
                        periph_b_in[n] <= 1'b0;
                        periph_c_in[n] <= filtered[n];
                        periph_d_in[n] <= 1'b0;
                    end
                    GMF_FUNC_D:
                    begin
                        periph_a_in[n] <= 1'b0;
                        periph_b_in[n] <= 1'b0;
                        periph_c_in[n] <= 1'b0;
                        periph_d_in[n] <= filtered[n];
                    end
                    default:
                    begin
                        periph_a_in[n] <= 1'b0;
                        periph_b_in[n] <= 1'b0;
                        periph_c_in[n] <= 1'b0;
                        periph_d_in[n] <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// ### sim/gmf_pad_model.sv
// Far side: pads that follow requested levels, and the slow clock pulse.
// Assumes pclk from the bench; all changes land just after a rising edge.
`timescale 1ns/10ps
`default_nettype none

module gmf_pad_model
#(
    parameter int TICK_DIV = 4
)
(
    input wire logic pclk, // Clock
    input wire logic [31:0] level, // Wanted line levels
    output logic [31:0] pin_in = '0, // Levels at the pads
    output logic slck_tick = 1'b0 // Slow clock pulse
);
    int cnt = 0;

    // Slow clock is a fraction of pclk, so ticks stay synchronous
    always @(posedge pclk)
    begin
        cnt <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
        slck_tick <= (cnt == TICK_DIV - 1);
        pin_in <= level;
    end
endmodule

`default_nettype wire

// ### sim/gmf_top_asserts.sv
// Checker for the line controller top: bus timing and register effects.
// Assumes a bind onto gmf_top; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
`include "gmf_defs.svh"

module gmf_top_asserts
(
    input wire logic pclk, // Clock
    input wire logic presetn, // Reset, active low
    input wire logic [31:0] paddr, // Address
    input wire logic psel, // Select
    input wire logic penable, // Access phase
    input wire logic pwrite, // Direction
    input wire logic [31:0] pwdata, // Write data
    input wire logic [31:0] prdata, // Read data
    input wire logic pready, // Ready
    input wire logic [31:0] periph_a_in, // Function A
    input wire logic [31:0] periph_b_in, // Function B
    input wire logic [31:0] periph_c_in, // Function C
    input wire logic [31:0] periph_d_in, // Function D
    input wire logic [31:0] pad_pulldown, // Pull-downs
    input wire logic [31:0] out_data // Output data
);
    logic wr;
    logic rd;
    logic wp;
    logic [31:0] wd;
    logic [31:0] dw;
    logic [31:0] clash;

    assign wr = psel && penable && pready && pwrite;
    assign rd = psel && penable && pready && !pwrite;
    assign clash = (periph_a_in & periph_b_in) | (periph_c_in & periph_d_in)
        | ((periph_a_in | periph_b_in) & (periph_c_in | periph_d_in));

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Own copy of protect bit and write gate
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wp <= 1'b0;
            wd <= '0;
            dw <= '0;
        end
        else if (wr)
        begin
            wd <= pwdata;
            if (paddr == `GMF_ADDR_WP_MODE)
                wp <= pwdata[0];
            if (!wp && paddr == `GMF_ADDR_DW_ON)
                dw <= dw | pwdata;
            if (!wp && paddr == `GMF_ADDR_DW_OFF)
                dw <= dw & ~pwdata;
        end
    end

    ready_pulse_a: assert property (psel && !penable
        |=> pready ##1 !pready)
        else $error("ready not a single cycle after setup");
    mux_single_a: assert property (clash == '0)
        else $error("line reaches two functions");
    pd_set_a: assert property (wr && !wp && paddr == `GMF_ADDR_PD_ON
        |-> ##[1:2] ((pad_pulldown & wd) == wd))
        else $error("pull-down not turned on");
    pd_clear_a: assert property (wr && !wp && paddr == `GMF_ADDR_PD_OFF
        |-> ##[1:2] ((pad_pulldown & wd) == '0))
        else $error("pull-down not turned off");
    wp_hold_a: assert property (wr && wp && (paddr == `GMF_ADDR_PD_ON
        || paddr == `GMF_ADDR_PD_OFF) |=> ##1 $stable(pad_pulldown))
        else $error("protected write changed pull-downs");
    out_hold_a: assert property (!(wr && paddr == `GMF_ADDR_OUT_DATA)
        |=> $stable(out_data))
        else $error("output data moved without a write");
    out_gate_a: assert property (wr && paddr == `GMF_ADDR_OUT_DATA
        |=> out_data == (($past(out_data) & ~dw) | (wd & dw)))
        else $error("output data ignores write gate");
    pd_read_a: assert property (rd && paddr == `GMF_ADDR_PD_STATE
        |-> prdata == ~pad_pulldown)
        else $error("pull-down state not inverted");
    dw_read_a: assert property (rd && paddr == `GMF_ADDR_DW_STATE
        |-> prdata == dw)
        else $error("write gate state wrong");
    wo_zero_a: assert property (rd && (paddr == `GMF_ADDR_PD_ON
        || paddr == `GMF_ADDR_DW_ON) |-> prdata == '0)
        else $error("write-only register reads nonzero");

    cover property (wr && wp);
    cover property (rd && paddr == `GMF_ADDR_PD_STATE);
    cover property (wr && paddr == `GMF_ADDR_OUT_DATA);
endmodule

bind gmf_top gmf_top_asserts i_gmf_top_asserts
(
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .periph_a_in(periph_a_in), .periph_b_in(periph_b_in),
    .periph_c_in(periph_c_in), .periph_d_in(periph_d_in),
    .pad_pulldown(pad_pulldown), .out_data(out_data)
);

`default_nettype wire

// ### sim/gmf_top_test.sv
// Self-checking bench for the line controller top over APB.
// Assumes the checker is bound in and the pad model is compiled.
`timescale 1ns/10ps
`default_nettype none
`include "gmf_defs.svh"

module gmf_top_test;
    import gmf_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slck_tick;
    gmf_word_type paddr, pwdata, prdata, pin_in, level, pad_pulldown;
    gmf_word_type pa, pb, pc, pd, out_data, q;
    logic e;
    int mismatches = 0;
    int checks = 0;
    int cycles = 0;

    gmf_top i_gmf_top (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .slck_tick(slck_tick), .pin_in(pin_in), .periph_a_in(pa),
        .periph_b_in(pb), .periph_c_in(pc), .periph_d_in(pd),
        .pad_pulldown(pad_pulldown), .out_data(out_data));
    gmf_pad_model i_gmf_pad_model (.pclk(pclk), .level(level),
        .pin_in(pin_in), .slck_tick(slck_tick));

    task automatic check(input gmf_word_type seen, input gmf_word_type exp,
        input string what);
        checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: %s %h not %h", $time, what, seen,
                exp);
        end
    endtask

    task automatic apb(input logic w, input gmf_word_type a,
        input gmf_word_type d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No assumed latency; only the cycle ceiling ends this wait
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input gmf_word_type a, input gmf_word_type d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input gmf_word_type a, input gmf_word_type x,
        input string what);
        apb(1'b0, a, 32'h0);
        check(q, x, what);
    endtask

    task automatic test_reset();
        rd(`GMF_ADDR_PD_STATE, 32'hffffffff, "pd state");
        rd(`GMF_ADDR_FLT_STATE, 32'h0, "filter state");
        rd(`GMF_ADDR_DW_STATE, 32'h0, "gate state");
        apb(1'b0, 32'h400e0e7c, 32'h0);
        check({31'h0, e}, 32'h1, "unmapped error");
        $display("test_reset done");
    endtask

    task automatic test_mux();
        level <= 32'hffffffff;
        wr(`GMF_ADDR_SEL_LOW, 32'h0000000a);
        wr(`GMF_ADDR_SEL_HIGH, 32'h0000000c);
        // Filter plus output register latency
        repeat (8) @(posedge pclk);
        check(pa, 32'hfffffff1, "function a");
        check(pb, 32'h00000002, "function b");
        check(pc, 32'h00000004, "function c");
        check(pd, 32'h00000008, "function d");
        rd(`GMF_ADDR_SEL_LOW, 32'h0000000a, "select low");
        rd(`GMF_ADDR_SEL_HIGH, 32'h0000000c, "select high");
        level <= 32'h0;
        $display("test_mux done");
    endtask

    task automatic test_filter();
        logic seen = 1'b0;
        wr(`GMF_ADDR_FLT_DEBOUNCE, 32'h00000f0f);
        wr(`GMF_ADDR_FLT_GLITCH, 32'h00000003);
        rd(`GMF_ADDR_FLT_STATE, 32'h00000f0c, "filter state");
        wr(`GMF_ADDR_DIVIDER, 32'hffffc001);
        rd(`GMF_ADDR_DIVIDER, 32'h00000001, "divider");
        repeat (8) @(posedge pclk);
        // Short pulses: one cycle on a glitch line, three on a debounce line
        level <= 32'h5;
        @(posedge pclk);
        level <= 32'h4;
        repeat (2) @(posedge pclk);
        level <= 32'h0;
        repeat (30)
        begin
            @(posedge pclk);
            seen = seen | pa[0] | pc[2];
        end
        check({31'h0, seen}, 32'h0, "pulse passed");
        level <= 32'h4;
        repeat (6) @(posedge pclk);
        check({31'h0, pc[2]}, 32'h0, "debounce too fast");
        repeat (34) @(posedge pclk);
        check({31'h0, pc[2]}, 32'h1, "debounce level");
        level <= 32'h0;
        $display("test_filter done");
    endtask

    task automatic test_protect();
        wr(`GMF_ADDR_PD_ON, 32'h000000a5);
        wr(`GMF_ADDR_PD_OFF, 32'h00000005);
        rd(`GMF_ADDR_PD_STATE, 32'hffffff5f, "pd state");
        check(pad_pulldown, 32'h000000a0, "pad pull-down");
        wr(`GMF_ADDR_WP_MODE, 32'hffffffff);
        rd(`GMF_ADDR_WP_MODE, 32'h00000001, "protect mode");
        wr(`GMF_ADDR_PD_ON, 32'hffff0000);
        wr(`GMF_ADDR_SEL_HIGH, 32'h0);
        wr(`GMF_ADDR_DW_ON, 32'hffffffff);
        rd(`GMF_ADDR_PD_STATE, 32'hffffff5f, "protected pd");
        rd(`GMF_ADDR_SEL_HIGH, 32'h0000000c, "protected sel");
        rd(`GMF_ADDR_DW_STATE, 32'h0, "protected gate");
        wr(`GMF_ADDR_WP_MODE, 32'h0);
        $display("test_protect done");
    endtask

    task automatic test_gate();
        wr(`GMF_ADDR_DW_ON, 32'h000000ff);
        wr(`GMF_ADDR_DW_OFF, 32'h0000000f);
        rd(`GMF_ADDR_DW_STATE, 32'h000000f0, "gate state");
        rd(`GMF_ADDR_DW_ON, 32'h0, "write-only");
        wr(`GMF_ADDR_OUT_DATA, 32'hffffffff);
        check(out_data, 32'h000000f0, "gated output");
        $display("test_gate done");
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            mismatches++;
            print_verdict();
        end
    end

    initial
    begin
        {presetn, psel, penable, pwrite} = 4'h0;
        {paddr, pwdata, level} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        test_reset();
        test_mux();
        test_filter();
        test_protect();
        test_gate();
        print_verdict();
    end
endmodule

`default_nettype wire
